// ---- issc_consts.svh ----
/*
 * constants for the interrupt, call stack and sleep controller:
 * register offsets, field positions, vector addresses and widths.
 * assumes a single core clock and an avalon-mm slave port.
 */
`ifndef ISSC_CONSTS_SVH
`define ISSC_CONSTS_SVH

// ************************************************************
// register offsets (byte address is four times the index)
// ************************************************************
`define ISSC_IDX_TIMER_MASK 8'h39
`define ISSC_IDX_EXT_MASK 8'h3b
`define ISSC_IDX_CORE_CTRL 8'h35
`define ISSC_IDX_TIMER_FLAGS 8'h38
`define ISSC_IDX_EXT_FLAGS 8'h3a
`define ISSC_IDX_STATUS 8'h3f
`define ISSC_IDX_SLEEP_STATE 8'h3e

// ************************************************************
// field positions
// ************************************************************
`define ISSC_BIT_EXT0_EN 6
`define ISSC_BIT_TOV_EN 1
`define ISSC_BIT_SE 5
`define ISSC_BIT_SM 4
`define ISSC_BIT_GIE 7
`define ISSC_BIT_ACMP 0
`define ISSC_EXT_MASK_RSVD 8'h80

// ************************************************************
// widths and vectors
// ************************************************************
`define ISSC_PC_W 9
`define ISSC_OFS_W 12
`define ISSC_STACK_DEPTH 3
`define ISSC_VEC_RESET 9'h000
`define ISSC_VEC_EXT0 9'h001
`define ISSC_VEC_TOV 9'h002
`define ISSC_VEC_ACMP 9'h003
`define ISSC_RST_VAL 8'h00

`endif

// ---- issc_pkg.sv ----
/*
 * types for the interrupt, call stack and sleep controller.
 * assumes the constants header is available for widths.
 */
`default_nettype none

package issc_pkg;
  // sleep controller states, one-hot
  typedef enum logic [2:0] {
    ISSC_RUN = 3'b001,
    ISSC_IDLE = 3'b010,
    ISSC_PDOWN = 3'b100
  } issc_sleep_t;

  // instruction sequencer stack command
  typedef enum logic [1:0] {
    ISSC_STK_NONE = 2'h0,
    ISSC_STK_PUSH = 2'h1,
    ISSC_STK_POP = 2'h2
  } issc_stk_op_t;
endpackage

`default_nettype wire

// ---- issc_ret_stack.sv ----
/*
 * three-entry return address stack for calls and interrupt entry.
 * assumes one push or pop per cycle from the caller; no overflow flag.
 */
`include "issc_consts.svh"
`default_nettype none

module issc_ret_stack (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // stack command
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [`ISSC_PC_W-1:0] push_data_i,
  // top of stack
  output logic [`ISSC_PC_W-1:0] top_o
);

  logic [`ISSC_PC_W-1:0] level_q [`ISSC_STACK_DEPTH];

  // *********************************************************
  // stack levels
  // *********************************************************
  // entry zero takes the new value, deeper entries shift
  genvar g;
  generate
    for (g = 0; g < `ISSC_STACK_DEPTH; g++) begin : g_lvl
      logic [`ISSC_PC_W-1:0] from_above;
      logic [`ISSC_PC_W-1:0] from_below;
      // neighbours; the bottom entry keeps its value on a pop
      if (g == 0) begin : g_first
        assign from_above = push_data_i;
      end else begin : g_next
        assign from_above = level_q[g-1]; // oldest drops out
      end
      if (g == `ISSC_STACK_DEPTH-1) begin : g_last
        assign from_below = level_q[g];
      end else begin : g_prev
        assign from_below = level_q[g+1];
      end
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          level_q[g] <= '0;
        end else if (push_i) begin
          level_q[g] <= from_above;
        end else if (pop_i) begin
          level_q[g] <= from_below;
        end
      end
    end
  endgenerate

  assign top_o = level_q[0];

endmodule

`default_nettype wire

// ---- issc_ctrl.sv ----
/*
 * interrupt, call stack and sleep controller of a small 8-bit core.
 * holds global enable, pending flags, mask registers, priority pick,
 * the return address stack, relative target math and sleep modes.
 * assumes the sequencer gives one-cycle command pulses and that
 * software reaches the registers over avalon-mm with waitrequest.
 */
// Behaviour
// - three return-address entries of nine bits each
// - call or interrupt entry pushes to entry zero, shifts deeper
// - return takes entry zero and shifts deeper entries up
// - beyond three nestings the oldest entry is lost silently
// - relative target is pc plus signed offset plus one
// - accepting an interrupt clears global enable
// - interrupt return or software write sets global enable
// - vectoring clears the flag of the taken source
// - writing one clears a flag, zero leaves it
// - flags set and hold even while their enable is clear
// - held flags are served in priority order once enabled
// - level external request has no latched flag
// - status register is never saved or restored by hardware
// - top bit of external mask reads zero
// - sleep only with sleep enable set and sleep executed
// - enabled interrupt wakes, handler runs, then resumes
// - reset while asleep restarts from the reset vector
// - mode select clear gives idle, interrupts still wake
// - wake from idle restarts at once
// - mode select set gives power-down, only level zero wakes
`include "issc_consts.svh"
`default_nettype none

module issc_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // interrupt sources
  input wire logic ext_external_interrupt_zero_n_i,
  input wire logic ext_external_interrupt_zero_edge_i,
  input wire logic timer_ovf_i,
  input wire logic acmp_i,
  // instruction sequencer
  input wire logic [`ISSC_PC_W-1:0] pc_i,
  input wire logic [`ISSC_OFS_W-1:0] rel_ofs_i,
  input wire logic rel_call_i,
  input wire logic rel_jump_i,
  input wire logic sub_ret_i,
  input wire logic int_ret_i,
  input wire logic sleep_i,
  input wire logic int_ack_i,
  // sequencer results
  output logic [`ISSC_PC_W-1:0] next_pc_o,
  output logic next_pc_vld_o,
  output logic int_req_o,
  output logic [`ISSC_PC_W-1:0] int_vec_o,
  output logic cpu_halt_o,
  output logic osc_stop_o,
  output logic global_en_o
);

  // *********************************************************
  // state
  // *********************************************************
  logic [7:0] timer_mask_q;
  logic [7:0] ext_mask_q;
  logic [7:0] ctrl_q;
  logic gie_q;
  logic ext0_flag_q;
  logic tov_flag_q;
  logic acmp_flag_q;
  issc_pkg::issc_sleep_t sleep_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic [`ISSC_PC_W-1:0] next_pc_q;
  logic next_pc_vld_q;
  logic int_req_q;
  logic [`ISSC_PC_W-1:0] int_vec_q;
  logic [`ISSC_PC_W-1:0] stack_top;
  logic [`ISSC_PC_W-1:0] rel_target;
  logic [`ISSC_PC_W-1:0] ret_addr;
  logic [`ISSC_PC_W-1:0] win_vec;
  logic win_any;
  logic ext0_req;
  logic tov_req;
  logic acmp_req;
  logic wr_acc;
  logic rd_acc;
  logic take_int;
  logic [7:0] wbyte;

  // *********************************************************
  // bus decode
  // *********************************************************
  // register hit test used by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  // one wait state: the access completes when waitrequest drops
  assign wr_acc = avs_write_i && !wait_q;
  assign rd_acc = avs_read_i && !wait_q;
  assign wbyte = avs_writedata_i[7:0];

  // waitrequest high for the first cycle of each access
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // *********************************************************
  // mask and control registers
  // *********************************************************
  // software-written masks; top external bit held zero
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_mask_q <= `ISSC_RST_VAL;
      ext_mask_q <= `ISSC_RST_VAL;
      ctrl_q <= `ISSC_RST_VAL;
    end else if (wr_acc) begin
      if (hit(avs_address_i, `ISSC_IDX_TIMER_MASK)) begin
        timer_mask_q <= wbyte;
      end
      if (hit(avs_address_i, `ISSC_IDX_EXT_MASK)) begin
        ext_mask_q <= wbyte & ~`ISSC_EXT_MASK_RSVD;
      end
      if (hit(avs_address_i, `ISSC_IDX_CORE_CTRL)) begin
        ctrl_q <= wbyte;
      end
    end
  end

  // *********************************************************
  // interrupt requests and priority
  // *********************************************************
  // level request has no flag, seen only while low
  assign ext0_req = !ext_external_interrupt_zero_n_i && ext_mask_q[`ISSC_BIT_EXT0_EN];
  assign tov_req = tov_flag_q && timer_mask_q[`ISSC_BIT_TOV_EN];
  assign acmp_req = acmp_flag_q;

  // lowest vector first
  always_comb begin
    win_any = 1'b1;
    if (ext0_req || (ext0_flag_q && ext_mask_q[`ISSC_BIT_EXT0_EN])) begin
      win_vec = `ISSC_VEC_EXT0;
    end else if (tov_req) begin
      win_vec = `ISSC_VEC_TOV;
    end else if (acmp_req) begin
      win_vec = `ISSC_VEC_ACMP;
    end else begin
      win_vec = `ISSC_VEC_RESET;
      win_any = 1'b0;
    end
  end

  // request held back until global enable is set
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_req_q <= 1'b0;
      int_vec_q <= `ISSC_VEC_RESET;
    end else begin
      int_req_q <= win_any && gie_q && !take_int;
      int_vec_q <= win_vec;
    end
  end

  assign take_int = int_ack_i && int_req_q;

  // *********************************************************
  // pending flags
  // *********************************************************
  // set wins over clear; flags hold regardless of enables
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext0_flag_q <= 1'b0;
      tov_flag_q <= 1'b0;
      acmp_flag_q <= 1'b0;
    end else begin
      if (ext0_edge_clr()) begin
        ext0_flag_q <= 1'b0;
      end
      if (ext_external_interrupt_zero_edge_i) begin
        ext0_flag_q <= 1'b1;
      end
      if (take_int && int_vec_q == `ISSC_VEC_TOV) begin
        tov_flag_q <= 1'b0;
      end else if (wr_acc && hit(avs_address_i, `ISSC_IDX_TIMER_FLAGS)
                   && wbyte[`ISSC_BIT_TOV_EN]) begin
        tov_flag_q <= 1'b0;
      end
      if (timer_ovf_i) begin
        tov_flag_q <= 1'b1;
      end
      if (take_int && int_vec_q == `ISSC_VEC_ACMP) begin
        acmp_flag_q <= 1'b0;
      end else if (wr_acc && hit(avs_address_i, `ISSC_IDX_EXT_FLAGS)
                   && wbyte[`ISSC_BIT_ACMP]) begin
        acmp_flag_q <= 1'b0;
      end
      if (acmp_i) begin
        acmp_flag_q <= 1'b1;
      end
    end
  end

  // clear of the edge flag by vectoring or write-one
  function automatic logic ext0_edge_clr();
    ext0_edge_clr = (take_int && int_vec_q == `ISSC_VEC_EXT0)
      || (wr_acc && hit(avs_address_i, `ISSC_IDX_EXT_FLAGS)
          && wbyte[`ISSC_BIT_EXT0_EN]);
  endfunction

  // *********************************************************
  // global interrupt enable
  // *********************************************************
  // status bit only; no save or restore on entry or return
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gie_q <= 1'b0;
    end else if (take_int) begin
      gie_q <= 1'b0;
    end else if (int_ret_i) begin
      gie_q <= 1'b1;
    end else if (wr_acc && hit(avs_address_i, `ISSC_IDX_STATUS)) begin
      gie_q <= wbyte[`ISSC_BIT_GIE];
    end
  end

  // *********************************************************
  // return stack and relative target
  // *********************************************************
  // pc plus sign-extended offset plus one, wrapped to pc width;
  // a call returns to the word after itself
  assign rel_target = `ISSC_PC_W'(pc_i + rel_ofs_i[`ISSC_PC_W-1:0]
                      + `ISSC_PC_W'(1));
  assign ret_addr = `ISSC_PC_W'(pc_i + `ISSC_PC_W'(1));

  issc_ret_stack u_stack (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .push_i(rel_call_i || take_int),
    .pop_i(sub_ret_i || int_ret_i),
    .push_data_i(take_int ? pc_i : ret_addr),
    .top_o(stack_top)
  );

  // redirect for jumps, calls and returns
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      next_pc_q <= `ISSC_VEC_RESET;
      next_pc_vld_q <= 1'b0;
    end else begin
      next_pc_vld_q <= rel_call_i || rel_jump_i || sub_ret_i || int_ret_i;
      if (rel_call_i || rel_jump_i) begin
        next_pc_q <= rel_target;
      end else if (sub_ret_i || int_ret_i) begin
        next_pc_q <= stack_top;
      end
    end
  end

  // *********************************************************
  // sleep controller
  // *********************************************************
  // enter on sleep with enable set; idle or power-down by mode bit
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_q <= issc_pkg::ISSC_RUN;
    end else begin
      unique case (sleep_q)
        issc_pkg::ISSC_RUN: begin
          if (sleep_i && ctrl_q[`ISSC_BIT_SE]) begin
            if (ctrl_q[`ISSC_BIT_SM]) begin
              sleep_q <= issc_pkg::ISSC_PDOWN;
            end else begin
              sleep_q <= issc_pkg::ISSC_IDLE;
            end
          end
        end
        issc_pkg::ISSC_IDLE: begin
          if (win_any) begin
            sleep_q <= issc_pkg::ISSC_RUN;
          end
        end
        issc_pkg::ISSC_PDOWN: begin
          // level low on input zero is the only interrupt wake
          if (ext0_req) begin
            sleep_q <= issc_pkg::ISSC_RUN;
          end
        end
        default: begin
          sleep_q <= issc_pkg::ISSC_RUN;
        end
      endcase
    end
  end

  // *********************************************************
  // read data
  // *********************************************************
  // unmapped addresses read zero
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= 32'h0000_0000;
      if (hit(avs_address_i, `ISSC_IDX_TIMER_MASK)) begin
        rdata_q[7:0] <= timer_mask_q;
      end
      if (hit(avs_address_i, `ISSC_IDX_EXT_MASK)) begin
        rdata_q[7:0] <= ext_mask_q & ~`ISSC_EXT_MASK_RSVD;
      end
      if (hit(avs_address_i, `ISSC_IDX_CORE_CTRL)) begin
        rdata_q[7:0] <= ctrl_q;
      end
      if (hit(avs_address_i, `ISSC_IDX_TIMER_FLAGS)) begin
        rdata_q[`ISSC_BIT_TOV_EN] <= tov_flag_q;
      end
      if (hit(avs_address_i, `ISSC_IDX_EXT_FLAGS)) begin
        rdata_q[`ISSC_BIT_EXT0_EN] <= ext0_flag_q;
        rdata_q[`ISSC_BIT_ACMP] <= acmp_flag_q;
      end
      if (hit(avs_address_i, `ISSC_IDX_STATUS)) begin
        rdata_q[`ISSC_BIT_GIE] <= gie_q;
      end
      if (hit(avs_address_i, `ISSC_IDX_SLEEP_STATE)) begin
        rdata_q[2:0] <= sleep_q;
      end
    end
  end

  // *********************************************************
  // outputs
  // *********************************************************
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign next_pc_o = next_pc_q;
  assign next_pc_vld_o = next_pc_vld_q;
  assign int_req_o = int_req_q;
  assign int_vec_o = int_vec_q;
  assign cpu_halt_o = (sleep_q != issc_pkg::ISSC_RUN);
  assign osc_stop_o = (sleep_q == issc_pkg::ISSC_PDOWN);
  assign global_en_o = gie_q;

  // unused high write bits
  logic unused_w;
  assign unused_w = ^avs_writedata_i[31:8] ^ rd_acc;

endmodule

`default_nettype wire

// ---- issc_ctrl_sva.sv ----
/*
 * assertion checker for issc_ctrl, watching its ports only.
 * assumes a bind from the testbench top file.
 */
`include "issc_consts.svh"
`default_nettype none

module issc_ctrl_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // sequencer side
  input wire logic [`ISSC_PC_W-1:0] pc_i,
  input wire logic [`ISSC_OFS_W-1:0] rel_ofs_i,
  input wire logic rel_jump_i,
  input wire logic sub_ret_i,
  input wire logic int_ret_i,
  input wire logic sleep_i,
  input wire logic int_ack_i,
  input wire logic [`ISSC_PC_W-1:0] next_pc_o,
  input wire logic next_pc_vld_o,
  input wire logic int_req_o,
  input wire logic [`ISSC_PC_W-1:0] int_vec_o,
  input wire logic cpu_halt_o,
  input wire logic osc_stop_o,
  input wire logic global_en_o
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // relative target wrapped to the pc width
  logic [`ISSC_PC_W-1:0] tgt;
  assign tgt = pc_i + rel_ofs_i[`ISSC_PC_W-1:0] + 9'h001;

  // entry handshake, then enable and request fall
  sequence s_enter; int_req_o && int_ack_i; endsequence
  sequence s_leave; !global_en_o ##1 !int_req_o; endsequence

  property p_jump; rel_jump_i |=> next_pc_vld_o && next_pc_o == $past(tgt);
  endproperty
  a_jump: assert property (p_jump) else $error("bad jump target");
  property p_ret; sub_ret_i |=> next_pc_vld_o; endproperty
  a_ret: assert property (p_ret) else $error("no return pc");
  property p_ack; s_enter |=> s_leave; endproperty
  a_ack: assert property (p_ack) else $error("enable kept");
  property p_interrupt_return; int_ret_i |=> global_en_o; endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("enable not set");
  property p_hold; !global_en_o ##1 !global_en_o |-> !int_req_o; endproperty
  a_hold: assert property (p_hold) else $error("req while off");
  property p_vec; int_req_o |-> int_vec_o inside {9'h001, 9'h002, 9'h003};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_halt; $rose(cpu_halt_o) |-> $past(sleep_i); endproperty
  a_halt: assert property (p_halt) else $error("halt unasked");
  property p_osc; osc_stop_o |-> cpu_halt_o; endproperty
  a_osc: assert property (p_osc) else $error("osc off, cpu on");
  property p_rsvd; avs_read_i && avs_waitrequest_o &&
    avs_address_i == `ISSC_IDX_EXT_MASK |=> !avs_readdata_o[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit7 set");
endmodule

`default_nettype wire

// ---- issc_seq_model.sv ----
/*
 * sequencer model: acknowledges a raised interrupt request.
 * assumes the controller holds its request until acknowledged.
 */
`default_nettype none

module issc_seq_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // bench control
  input wire logic ack_en_i,
  input wire logic [3:0] delay_i,
  // controller side
  input wire logic int_req_i,
  input wire logic [8:0] int_vec_i,
  output logic int_ack_o,
  output logic [8:0] taken_vec_o
);
  logic [3:0] cnt_q;
  logic done_q;

  // one acknowledge per request, after a set wait
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      int_ack_o <= 1'b0;
      taken_vec_o <= 9'h000;
    end else begin
      int_ack_o <= 1'b0;
      if (!int_req_i) begin
        cnt_q <= 4'h0;
        done_q <= 1'b0;
      end else if (ack_en_i && !done_q) begin
        if (cnt_q == delay_i) begin
          int_ack_o <= 1'b1;
          done_q <= 1'b1;
          taken_vec_o <= int_vec_i;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- test_issc_ctrl.sv ----
/*
 * self-checking bench for issc_ctrl with a sequencer model.
 * assumes design, header, package and model compile first.
 */
`default_nettype none

module test_issc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // wiring
  // ********
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic ext_external_interrupt_zero_n_i = 1'b1;
  logic ext_external_interrupt_zero_edge_i, timer_ovf_i, acmp_i, sleep_i, int_ack_i;
  logic int_ret_i, sub_ret_i, rel_call_i, rel_jump_i;
  logic [8:0] pc_i = 9'h000;
  logic [11:0] rel_ofs_i = 12'h000;
  logic [7:0] cmd = 8'h00;
  logic ack_en = 1'b1;
  logic [3:0] ack_dly = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, next_pc_vld_o, int_req_o, cpu_halt_o;
  logic osc_stop_o, global_en_o;
  logic [8:0] next_pc_o, int_vec_o, taken, rdq;
  logic [2:0] flags;
  logic [37:0] rows [5];
  int fail_count = 0;
  int samples_checked = 0;

  // command pulses fan out to the sequencer and source pins
  assign {acmp_i, timer_ovf_i, ext_external_interrupt_zero_edge_i, sleep_i} = cmd[7:4];
  assign {int_ret_i, sub_ret_i, rel_call_i, rel_jump_i} = cmd[3:0];
  assign flags = {int_req_o, cpu_halt_o, global_en_o};
  always #2 sys_clk_i = ~sys_clk_i;

  issc_ctrl u_dut (.sys_clk_i, .rstn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .ext_external_interrupt_zero_n_i, .ext_external_interrupt_zero_edge_i, .timer_ovf_i, .acmp_i, .pc_i,
    .rel_ofs_i, .rel_call_i, .rel_jump_i, .sub_ret_i, .int_ret_i,
    .sleep_i, .int_ack_i, .next_pc_o, .next_pc_vld_o, .int_req_o,
    .int_vec_o, .cpu_halt_o, .osc_stop_o, .global_en_o);
  issc_seq_model u_seq (.sys_clk_i, .rstn_i, .ack_en_i(ack_en),
    .delay_i(ack_dly), .int_req_i(int_req_o), .int_vec_i(int_vec_o),
    .int_ack_o(int_ack_i), .taken_vec_o(taken));

  // ********
  // tasks
  // ********
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task check(input string nm, input logic [8:0] got, input logic [8:0] e);
    samples_checked++;
    if (got !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, got);
      fail_count++;
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
    rdq = {1'b0, avs_readdata_o[7:0]};
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task rc(input logic [7:0] a, input logic [8:0] e);
    bus(1'b0, a, 8'h00);
    check("readdata", rdq, e);
  endtask

  task go(input logic [7:0] m);
    @(posedge sys_clk_i);
    cmd <= m;
    @(posedge sys_clk_i);
    cmd <= 8'h00;
  endtask

  task wait_for(input int s, input logic v);
    int n;
    n = 0;
    while (flags[s] !== v && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (flags[s] !== v) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // flag a comparator event, enable, wait for the model's entry
  task take(input logic [8:0] p, input logic [8:0] v);
    pc_i <= p;
    go(8'h80);
    bus(1'b1, 8'h3f, 8'h80);
    wait_for(2, 1'b1);
    wait_for(0, 1'b0);
    check("vector", taken, v);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    rows[0] = {9'h010, 12'h7ff, 8'h01, 9'h010};
    rows[1] = {9'h100, 12'h800, 8'h01, 9'h101};
    rows[2] = {9'h1ff, 12'h000, 8'h02, 9'h000};
    rows[3] = {9'h005, 12'hffe, 8'h02, 9'h004};
    rows[4] = {9'h0aa, 12'h000, 8'h04, 9'h006};
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rc(8'h39, 9'h000); // reset value
    rc(8'h3b, 9'h000); // reset value
    rc(8'h00, 9'h000); // unmapped
    foreach (rows[i]) begin
      pc_i <= rows[i][37:29];
      rel_ofs_i <= rows[i][28:17];
      go(rows[i][16:9]);
      @(posedge sys_clk_i);
      check("target", next_pc_o, rows[i][8:0]);
    end
    for (int i = 1; i < 5; i++) take(9'(i * 17), 9'h003);
    rc(8'h3a, 9'h000);
    for (int i = 0; i < 3; i++) begin
      go(i == 2 ? 8'h08 : 8'h04);
      @(posedge sys_clk_i);
      check("pop", next_pc_o, 9'(68 - 17 * i));
    end
    check("enable", {8'h00, global_en_o}, 9'h001);
    bus(1'b1, 8'h3f, 8'h00);
    go(8'he0);
    rc(8'h3a, 9'h041);
    rc(8'h38, 9'h002);
    bus(1'b1, 8'h3a, 8'h00);
    rc(8'h3a, 9'h041);
    bus(1'b1, 8'h3a, 8'h01);
    rc(8'h3a, 9'h040);
    go(8'h80);
    bus(1'b1, 8'h39, 8'hff);
    rc(8'h39, 9'h0ff); // read-write mask
    bus(1'b1, 8'h3b, 8'hff);
    rc(8'h3b, 9'h07f);
    ack_dly <= 4'h3;
    for (int v = 1; v < 4; v++) take(pc_i, 9'(v));
    ack_en <= 1'b0;
    ext_external_interrupt_zero_n_i <= 1'b0;
    bus(1'b1, 8'h3f, 8'h80);
    wait_for(2, 1'b1);
    check("level vec", int_vec_o, 9'h001);
    ext_external_interrupt_zero_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    check("level req", {8'h00, int_req_o}, 9'h000);
    rc(8'h3a, 9'h000);
    ack_en <= 1'b1;
    go(8'h10);
    repeat (2) @(posedge sys_clk_i);
    check("halt", {8'h00, cpu_halt_o}, 9'h000);
    bus(1'b1, 8'h35, 8'h20);
    go(8'h10);
    wait_for(1, 1'b1);
    rc(8'h3e, 9'h002);
    go(8'h80);
    wait_for(1, 1'b0);
    bus(1'b1, 8'h3f, 8'h80);
    ack_en <= 1'b0;
    bus(1'b1, 8'h35, 8'h30);
    go(8'h10);
    wait_for(1, 1'b1);
    check("osc", {8'h00, osc_stop_o}, 9'h001);
    go(8'h80);
    repeat (10) @(posedge sys_clk_i);
    check("asleep", {8'h00, cpu_halt_o}, 9'h001);
    ext_external_interrupt_zero_n_i <= 1'b0; // held until the halt is seen to drop
    wait_for(1, 1'b0);
    ext_external_interrupt_zero_n_i <= 1'b1;
    ack_en <= 1'b1;
    go(8'h10);
    wait_for(1, 1'b1);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    check("halt", {8'h00, cpu_halt_o}, 9'h000);
    check("pc", next_pc_o, 9'h000);
    rc(8'h3e, 9'h001);
    report_and_stop();
  end
endmodule

bind issc_ctrl issc_ctrl_sva u_sva (.sys_clk_i, .rstn_i, .avs_address_i,
  .avs_read_i, .avs_readdata_o, .avs_waitrequest_o, .pc_i, .rel_ofs_i,
  .rel_jump_i, .sub_ret_i, .int_ret_i, .sleep_i, .int_ack_i, .next_pc_o,
  .next_pc_vld_o, .int_req_o, .int_vec_o, .cpu_halt_o, .osc_stop_o,
  .global_en_o);

`default_nettype wire
